// ### rtl/lsd_map.vh
`ifndef LSD_MAP_VH
`define LSD_MAP_VH
`define LSD_NCH          16
`define LSD_CLK_MHZ      100
`define LSD_CHECK_NS     2000
`define LSD_CHECK_CYC    ((`LSD_CHECK_NS * `LSD_CLK_MHZ + 999) / 1000)
`define LSD_CNT_W        12
`define LSD_PAT_W        10
`define LSD_PAT_ENTER    10'h22e
`define LSD_PAT_EXIT     10'h22a
`define LSD_LOW_SAMPLES  3
`endif

// ### rtl/lsd_sync.v
`timescale 1ns/1ns
`default_nettype none
module lsd_sync #(
	parameter W = 1
) (
	input  wire         clk_sys_i,
	input  wire         rst_i,
	input  wire [W-1:0] d_i,
	output reg  [W-1:0] q_o
);
	reg [W-1:0] meta_q;
	always @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			meta_q <= {W{1'b0}};
			q_o    <= {W{1'b0}};
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end
endmodule // lsd_sync
`default_nettype wire

// ### rtl/lsd_top.v
`timescale 1ns/1ns
`default_nettype none
`include "lsd_map.vh"
// Notes on behaviour
// - five sampled (gate,strobe) pairs 10,00,10,11,10 enter detection mode
// - five sampled pairs 10,00,10,10,10 return to normal mode
// - serial data keeps shifting in while a mode pattern is clocked, except on a gate-low pair in detection mode, which starts a check
// - in detection mode, gate falling starts the current check
// - open channel records 0, good channel records 1
// - no serial input accepted while the check runs
// - qualifying last low sample captures all check results
// - with gate high after capture, each clock shifts one status bit out
// - status loads into the same shift register that carries data
module lsd_top (
	input  wire                  clk_sys_i,
	input  wire                  rst_i,
	input  wire                  serial_clk_i,
	input  wire                  serial_in_line_i,
	input  wire                  latch_strobe_line_i,
	input  wire                  output_gate_line_n_i,
	input  wire [`LSD_NCH-1:0]   sink_current_ok_i,
	output reg                   serial_out_line_o,
	output reg  [`LSD_NCH-1:0]   sink_channel_on_o,
	output reg                   detect_mode_o,
	output reg                   check_busy_o
);
	wire [3:0] sync_w;
	lsd_sync #(.W(4)) u_sync (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.d_i       ({serial_clk_i, serial_in_line_i, latch_strobe_line_i, output_gate_line_n_i}),
		.q_o       (sync_w)
	);
	wire sclk_w   = sync_w[3];
	wire sdi_w    = sync_w[2];
	wire strobe_w = sync_w[1];
	wire gate_n_w = sync_w[0];
	// comparator outputs settle on their own time; two stages before capture
	wire [`LSD_NCH-1:0] ok_sync_w;
	lsd_sync #(.W(`LSD_NCH)) u_ok_sync (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.d_i       (sink_current_ok_i),
		.q_o       (ok_sync_w)
	);

	reg                  sclk_q;
	reg                  gate_n_q;
	reg [`LSD_NCH-1:0]   shift_q;
	reg [`LSD_NCH-1:0]   latch_q;
	reg [`LSD_PAT_W-1:0] pat_q;
	reg [1:0]            low_cnt_q;
	reg [`LSD_CNT_W-1:0] tmr_q;

	wire rise_w = sclk_w & ~sclk_q;
	wire gate_fall_w = ~gate_n_w & gate_n_q;
	wire start_w = detect_mode_o & gate_fall_w & ~check_busy_o;
	wire timer_done_w = (tmr_q >= `LSD_CHECK_CYC);
	wire [`LSD_PAT_W-1:0] pat_d = {pat_q[`LSD_PAT_W-3:0], gate_n_w, strobe_w};
	wire [1:0] low_cnt_d = (low_cnt_q == 2'h3) ? 2'h3 : low_cnt_q + 2'h1;
	// capture on a low sample that is at least the third and past 2us
	wire capture_w = check_busy_o & rise_w & ~gate_n_w &
		(low_cnt_d >= `LSD_LOW_SAMPLES) & timer_done_w;

	always @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			sclk_q            <= 1'b0;
			// same level as the synchroniser's reset output, so no false fall
			gate_n_q          <= 1'b0;
			shift_q           <= 16'h0000;
			latch_q           <= 16'h0000;
			pat_q             <= 10'h000;
			low_cnt_q         <= 2'h0;
			tmr_q             <= 12'h000;
			detect_mode_o     <= 1'b0;
			check_busy_o      <= 1'b0;
			serial_out_line_o <= 1'b0;
			sink_channel_on_o <= 16'h0000;
		end else begin
			sclk_q   <= sclk_w;
			gate_n_q <= gate_n_w;
			if (start_w) begin
				check_busy_o <= 1'b1;
				tmr_q        <= 12'h000;
				low_cnt_q    <= 2'h0;
			end else if (check_busy_o && gate_n_w) begin
				// gate rose before capture: check abandoned at once, nothing stored
				check_busy_o <= 1'b0;
			end else if (check_busy_o && !timer_done_w) begin
				tmr_q <= tmr_q + 12'h001;
			end
			if (rise_w) begin
				pat_q <= pat_d;
				if (pat_d == `LSD_PAT_ENTER)
					detect_mode_o <= 1'b1;
				else if (pat_d == `LSD_PAT_EXIT)
					detect_mode_o <= 1'b0;
				if (capture_w) begin
					// results replace data in the one shift chain
					shift_q      <= ok_sync_w;
					check_busy_o <= 1'b0;
				end else if (check_busy_o) begin
					if (!gate_n_w)
						low_cnt_q <= low_cnt_d;
				end else if (!start_w) begin
					// a rise on the cycle the check starts is not taken as data
					// shifts also during status readout and patterns, but not on a gate-low pair in detection mode
					shift_q <= {shift_q[`LSD_NCH-2:0], sdi_w};
				end
			end
			serial_out_line_o <= shift_q[`LSD_NCH-1];
			if (strobe_w)
				latch_q <= shift_q;
			// sinks driven only while gate low
			sink_channel_on_o <= gate_n_w ? 16'h0000 : latch_q;
		end
	end
endmodule // lsd_top
`default_nettype wire

// ### test/lsd_chk_sva.sv
`timescale 1ns/1ns
`default_nettype none
module lsd_chk (
	input wire logic        clk_sys_i,
	input wire logic        rst_i,
	input wire logic        serial_clk_i,
	input wire logic        output_gate_line_n_i,
	input wire logic        serial_out_line_o,
	input wire logic        detect_mode_o,
	input wire logic        check_busy_o,
	input wire logic [15:0] sink_channel_on_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	sequence gate_hi; output_gate_line_n_i[*4]; endsequence
	mode_hold_a: assert property (!serial_clk_i[*6] |=> $stable(detect_mode_o)) else $error("mode");
	sdo_hold_a: assert property (serial_clk_i[*6] |=> $stable(serial_out_line_o)) else $error("sdo");
	busy_start_a: assert property ($rose(check_busy_o) |-> !output_gate_line_n_i) else $error("start");
	busy_mode_a: assert property (check_busy_o |-> detect_mode_o) else $error("mode");
	busy_len_a: assert property ($fell(check_busy_o) && !output_gate_line_n_i |-> $past(check_busy_o, 199))
		else $error("len");
	busy_end_a: assert property (gate_hi |-> !check_busy_o) else $error("end");
	busy_frozen_a: assert property (check_busy_o |=> $stable(serial_out_line_o)) else $error("frozen");
	sink_off_a: assert property (gate_hi |-> !sink_channel_on_o) else $error("off");
endmodule // lsd_chk
bind lsd_top lsd_chk chk (
	.clk_sys_i            (clk_sys_i),
	.rst_i                (rst_i),
	.serial_clk_i         (serial_clk_i),
	.output_gate_line_n_i (output_gate_line_n_i),
	.serial_out_line_o    (serial_out_line_o),
	.detect_mode_o        (detect_mode_o),
	.check_busy_o         (check_busy_o),
	.sink_channel_on_o    (sink_channel_on_o)
);
`default_nettype wire

// ### test/lsd_ctl.sv
`timescale 1ns/1ns
`default_nettype none
module lsd_ctl (
	input  wire logic clk_sys_i,
	output var  logic sclk_o,
	output var  logic sdi_o,
	output var  logic le_o,
	output var  logic gate_n_o
);
	initial {sclk_o, sdi_o, le_o, gate_n_o} = 4'h1;
	// pins settle a cycle before the rise and hold well past it
	task tick(logic g, l, d);
		@(posedge clk_sys_i) {sclk_o, gate_n_o, le_o, sdi_o} <= {1'b0, g, l, d};
		repeat (4) @(posedge clk_sys_i) sclk_o <= '1;
		repeat (4) @(posedge clk_sys_i) sclk_o <= '0;
	endtask
endmodule // lsd_ctl
`default_nettype wire

// ### test/test_led_sink_open_detect_mode.sv
`timescale 1ns/1ns
`default_nettype none
module test_led_sink_open_detect_mode;
	logic clk_sys_i = 0, rst_i = 1, sc, sd, le, gn, so, dm, bz;
	logic [15:0] ok = 16'ha5c3, sk;
	int err_total = 0, n_compared = 0, cyc = 0;
	always #5 clk_sys_i = ~clk_sys_i;
	lsd_ctl P (.clk_sys_i, .sclk_o(sc), .sdi_o(sd), .le_o(le), .gate_n_o(gn));
	lsd_top DUT (.clk_sys_i, .rst_i, .serial_clk_i(sc), .serial_in_line_i(sd), .latch_strobe_line_i(le),
		.output_gate_line_n_i(gn), .sink_current_ok_i(ok), .serial_out_line_o(so),
		.sink_channel_on_o(sk), .detect_mode_o(dm), .check_busy_o(bz));
	task cmp(string s, logic [15:0] e, a);
		n_compared++;
		err_total += (a !== e);
		if (a !== e) $display("[FAIL] %s exp %h got %h", s, e, a);
	endtask
	task results;
		$display("%0d of %0d failed", err_total, n_compared);
		if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk_sys_i) if (++cyc > 3000) begin err_total++; results; end
	task t_norm;
		for (int i = 15; i >= 0; i--) P.tick('1, i == 0, ok[i]);
		P.tick('0, '0, '0);
		cmp("sinks", ok, sk);
		$display("normal end");
	endtask
	task t_mode(logic [9:0] p, logic e);
		for (int i = 4; i >= 0; i--) P.tick(p[2*i+1], p[2*i], i[0]);
		cmp("mode", 16'(e), 16'(dm));
		$display("mode end");
	endtask
	task t_chk;
		P.tick('0, '0, '1);
		cmp("busy", 16'h1, 16'(bz));
		repeat (200) @(posedge clk_sys_i);
		repeat (2) P.tick('0, '0, '1);
		for (int i = 15; i >= 0; i--) begin
			cmp("status", 16'(ok[i]), 16'(so));
			P.tick('1, '0, '0);
		end
		$display("check end");
	endtask
	initial begin
		repeat (3) @(posedge clk_sys_i);
		rst_i <= 0;
		t_norm;
		t_mode(10'h22e, '1);
		t_chk;
		t_mode(10'h22b, '1);
		t_mode(10'h22a, '0);
		results;
	end
endmodule // test_led_sink_open_detect_mode
`default_nettype wire
